//--- common/serial_port_defines.svh
`ifndef SERIAL_PORT_DEFINES_SVH
`define SERIAL_PORT_DEFINES_SVH

// register addresses on the plain register port
`define SERIAL_PORT_CONTROL_ADDR  8'h98
`define SERIAL_BUFFER_ADDR        8'h99

// reset values
`define SERIAL_PORT_CONTROL_RESET 8'h00
`define SERIAL_BUFFER_RESET       8'h00

// field positions in serial_port_control
`define MODE_SELECT_HIGH_POS      3'h7
`define MODE_SELECT_LOW_POS       3'h6
`define MULTIPROCESSOR_ENABLE_POS 3'h5
`define RX_ENABLE_POS             3'h4
`define TX_NINTH_BIT_POS          3'h3
`define RX_NINTH_BIT_POS          3'h2
`define TX_DONE_FLAG_POS          3'h1
`define RX_DONE_FLAG_POS          3'h0

// timing counts
`define OVERSAMPLE_LAST           4'hF
`define SAMPLE_POINT              4'h7
`define SHIFT_CLOCK_LAST          4'hB
`define SHIFT_CLOCK_RISE          4'h6
`define MODE2_DIV32_MASK          2'h1
`define MODE2_DIV64_MASK          2'h3
`define LAST_DATA_BIT             3'h7

`endif

//--- common/serial_port_pkg.sv
package serial_port_pkg;

  typedef enum logic [1:0] {
    MODE_SHIFT       = 2'h0,
    MODE_UART8       = 2'h1,
    MODE_UART9_FIXED = 2'h2,
    MODE_UART9_VAR   = 2'h3
  } serial_mode_t;

  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_NINTH = 4'h8
  } tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_NINTH = 5'h08,
    RX_STOP  = 5'h10
  } rx_state_t;

  typedef enum logic [2:0] {
    M0_IDLE = 3'h1,
    M0_TX   = 3'h2,
    M0_RX   = 3'h4
  } m0_state_t;

endpackage

//--- rtl/four_mode_serial_port.sv
`timescale 1ns/10ps
`include "serial_port_defines.svh"
module four_mode_serial_port
  import serial_port_pkg::*;
(
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rstn_in,
  // register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // baud sources
  input  wire logic       timer1_ovf_in,
  input  wire logic       timer2_ovf_in,
  input  wire logic       rx_clock_select_in,
  input  wire logic       tx_clock_select_in,
  input  wire logic       div64_select_in,
  // serial line
  input  wire logic       rxd_in,
  output logic            rxd_out,
  output logic            rxd_oe_n_out,
  output logic            txd_out
);

  function automatic logic is_async(input serial_mode_t m);
    return m != MODE_SHIFT;
  endfunction

  function automatic logic has_ninth(input serial_mode_t m);
    return (m == MODE_UART9_FIXED) || (m == MODE_UART9_VAR);
  endfunction

  logic [7:0]   serial_port_control;
  logic [7:0]   rx_buffer;
  serial_mode_t mode;
  logic         mpe;
  logic         rx_enable;
  logic         rx_done;
  logic         wr_buf;
  logic         wr_ctrl;
  logic         rd_buf;
  logic         rd_ctrl;

  assign mode      = serial_mode_t'(
                       {serial_port_control[`MODE_SELECT_HIGH_POS],
                        serial_port_control[`MODE_SELECT_LOW_POS]});
  assign mpe       = serial_port_control[`MULTIPROCESSOR_ENABLE_POS];
  assign rx_enable = serial_port_control[`RX_ENABLE_POS];
  assign rx_done   = serial_port_control[`RX_DONE_FLAG_POS];
  assign wr_buf    = wr_in && (addr_in == `SERIAL_BUFFER_ADDR);
  assign wr_ctrl   = wr_in && (addr_in == `SERIAL_PORT_CONTROL_ADDR);
  assign rd_buf    = rd_in && (addr_in == `SERIAL_BUFFER_ADDR);
  assign rd_ctrl   = rd_in && (addr_in == `SERIAL_PORT_CONTROL_ADDR);

  // rxd synchroniser; rxd_prev only feeds the start edge detector
  logic rxd_meta;
  logic rxd_sync;
  logic rxd_prev;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      rxd_prev <= 1'b1;
    end else begin
      rxd_meta <= rxd_in;
      rxd_sync <= rxd_meta;
      rxd_prev <= rxd_sync;
    end
  end

  // baud ticks at sixteen per bit time
  logic [1:0] fixed_cnt;
  logic [1:0] fixed_mask;
  logic       fixed_tick;
  logic       tx_tick;
  logic       rx_tick;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fixed_cnt <= 2'h0;
    end else begin
      fixed_cnt <= fixed_cnt + 2'h1;
    end
  end

  assign fixed_mask = div64_select_in ? `MODE2_DIV64_MASK
                                      : `MODE2_DIV32_MASK;
  assign fixed_tick = (fixed_cnt & fixed_mask) == fixed_mask;
  // overflow pulses are the 16x tick, so baud is overflow rate / 16
  assign tx_tick = (mode == MODE_UART9_FIXED) ? fixed_tick
                 : (tx_clock_select_in ? timer2_ovf_in
                                       : timer1_ovf_in);
  assign rx_tick = (mode == MODE_UART9_FIXED) ? fixed_tick
                 : (rx_clock_select_in ? timer2_ovf_in
                                       : timer1_ovf_in);

  // asynchronous transmitter
  tx_state_t tx_state;
  logic [3:0] tx_phase;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic       tx_stop;
  logic       tx_bit_end;
  logic       tx_ti_set;
  logic       tx_line;

  assign tx_bit_end = tx_tick && (tx_phase == `OVERSAMPLE_LAST);

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_state <= TX_IDLE;
      tx_phase <= 4'h0;
      tx_bit   <= 3'h0;
      tx_shift <= 8'h00;
      tx_stop  <= 1'b0;
    end else if (wr_buf && is_async(mode)) begin
      tx_state <= TX_START;
      tx_phase <= 4'h0;
      tx_bit   <= 3'h0;
      tx_shift <= wdata_in;
      tx_stop  <= 1'b0;
    end else if (!is_async(mode)) begin
      tx_state <= TX_IDLE;
      tx_stop  <= 1'b0;
    end else begin
      if (tx_tick) begin
        tx_phase <= tx_phase + 4'h1;
      end
      if (tx_bit_end) begin
        case (tx_state)
          TX_START: begin
            tx_state <= TX_DATA;
          end
          TX_DATA: begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit   <= tx_bit + 3'h1;
            if (tx_bit == `LAST_DATA_BIT) begin
              if (has_ninth(mode)) begin
                tx_state <= TX_NINTH;
              end else begin
                tx_state <= TX_IDLE;
                tx_stop  <= 1'b1;
              end
            end
          end
          TX_NINTH: begin
            tx_state <= TX_IDLE;
            tx_stop  <= 1'b1;
          end
          default: begin
            tx_state <= TX_IDLE;
            tx_stop  <= 1'b0;
          end
        endcase
        // the stop bit is the idle level; its time ends here
        if (tx_state == TX_IDLE) begin
          tx_stop <= 1'b0;
        end
      end
    end
  end

  assign tx_ti_set = tx_bit_end &&
                     ((tx_state == TX_NINTH) ||
                      ((tx_state == TX_DATA) &&
                       (tx_bit == `LAST_DATA_BIT) &&
                       !has_ninth(mode)));

  always_comb begin
    case (tx_state)
      TX_START: tx_line = 1'b0;
      TX_DATA:  tx_line = tx_shift[0];
      TX_NINTH: tx_line = serial_port_control[`TX_NINTH_BIT_POS];
      default:  tx_line = 1'b1;
    endcase
  end

  // asynchronous receiver, acts once per bit at the sample point
  rx_state_t rx_state;
  logic [3:0] rx_phase;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic       rx_ninth_cap;
  logic       rx_mid;
  logic       start_edge;
  logic       rx_finish;
  logic       async_accept;
  logic       rb8_value;

  assign rx_mid     = rx_tick && (rx_phase == `SAMPLE_POINT);
  assign start_edge = rx_enable && is_async(mode) &&
                      rxd_prev && !rxd_sync;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_state     <= RX_IDLE;
      rx_phase     <= 4'h0;
      rx_bit       <= 3'h0;
      rx_shift     <= 8'h00;
      rx_ninth_cap <= 1'b0;
    end else if (!is_async(mode)) begin
      rx_state <= RX_IDLE;
    end else if (rx_state == RX_IDLE) begin
      if (start_edge) begin
        rx_state <= RX_START;
        rx_phase <= 4'h0;
        rx_bit   <= 3'h0;
      end
    end else begin
      if (rx_tick) begin
        rx_phase <= rx_phase + 4'h1;
      end
      if (rx_mid) begin
        case (rx_state)
          RX_START: begin
            // a high level at mid start bit was a glitch
            rx_state <= rxd_sync ? RX_IDLE : RX_DATA;
          end
          RX_DATA: begin
            rx_shift <= {rxd_sync, rx_shift[7:1]};
            rx_bit   <= rx_bit + 3'h1;
            if (rx_bit == `LAST_DATA_BIT) begin
              rx_state <= has_ninth(mode) ? RX_NINTH : RX_STOP;
            end
          end
          RX_NINTH: begin
            rx_ninth_cap <= rxd_sync;
            rx_state     <= RX_STOP;
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // ends at mid stop so the next start edge is already watched for
  assign rx_finish    = rx_mid && (rx_state == RX_STOP);
  assign rb8_value    = has_ninth(mode) ? rx_ninth_cap : rxd_sync;
  assign async_accept = rx_finish && !rx_done &&
                        (!mpe || rb8_value);

  // mode 0 shift engine, one shift register for both directions
  m0_state_t m0_state;
  logic [3:0] m0_cnt;
  logic [2:0] m0_bit;
  logic [7:0] m0_shift;
  logic       m0_last;
  logic       m0_tx_done;
  logic       m0_rx_done;

  assign m0_last = m0_cnt == `SHIFT_CLOCK_LAST;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      m0_state <= M0_IDLE;
      m0_cnt   <= 4'h0;
      m0_bit   <= 3'h0;
      m0_shift <= 8'h00;
    end else if (wr_buf && (mode == MODE_SHIFT)) begin
      m0_state <= M0_TX;
      m0_cnt   <= 4'h0;
      m0_bit   <= 3'h0;
      m0_shift <= wdata_in;
    end else if (mode != MODE_SHIFT) begin
      m0_state <= M0_IDLE;
    end else begin
      case (m0_state)
        M0_IDLE: begin
          if (rx_enable && !rx_done) begin
            m0_state <= M0_RX;
            m0_cnt   <= 4'h0;
            m0_bit   <= 3'h0;
          end
        end
        M0_TX, M0_RX: begin
          m0_cnt <= m0_last ? 4'h0 : m0_cnt + 4'h1;
          if ((m0_state == M0_RX) && (m0_cnt == `SHIFT_CLOCK_RISE)) begin
            m0_shift <= {rxd_sync, m0_shift[7:1]};
          end
          if (m0_last) begin
            if (m0_state == M0_TX) begin
              m0_shift <= {1'b0, m0_shift[7:1]};
            end
            m0_bit <= m0_bit + 3'h1;
            if (m0_bit == `LAST_DATA_BIT) begin
              m0_state <= M0_IDLE;
            end
          end
        end
        default: begin
          m0_state <= M0_IDLE;
        end
      endcase
    end
  end

  assign m0_tx_done = (m0_state == M0_TX) && m0_last &&
                      (m0_bit == `LAST_DATA_BIT) && !wr_buf;
  assign m0_rx_done = (m0_state == M0_RX) && m0_last &&
                      (m0_bit == `LAST_DATA_BIT) && !wr_buf;

  // receive buffer, separate from the transmit path
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_buffer <= `SERIAL_BUFFER_RESET;
    end else if (async_accept) begin
      rx_buffer <= rx_shift;
    end else if (m0_rx_done) begin
      rx_buffer <= m0_shift;
    end
  end

  // control register; hardware sets land after the write so they win
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serial_port_control <= `SERIAL_PORT_CONTROL_RESET;
    end else begin
      if (wr_ctrl) begin
        serial_port_control <= wdata_in;
      end
      if (tx_ti_set || m0_tx_done) begin
        serial_port_control[`TX_DONE_FLAG_POS] <= 1'b1;
      end
      if (async_accept) begin
        serial_port_control[`RX_NINTH_BIT_POS] <= rb8_value;
        serial_port_control[`RX_DONE_FLAG_POS] <= 1'b1;
      end
      if (m0_rx_done) begin
        serial_port_control[`RX_DONE_FLAG_POS] <= 1'b1;
      end
    end
  end

  // pins; shift clock low for the first half of each mode 0 bit
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      txd_out      <= 1'b1;
      rxd_out      <= 1'b1;
      rxd_oe_n_out <= 1'b1;
    end else if (mode == MODE_SHIFT) begin
      txd_out      <= (m0_state == M0_IDLE) ||
                      (m0_cnt >= `SHIFT_CLOCK_RISE);
      rxd_out      <= (m0_state == M0_TX) ? m0_shift[0] : 1'b1;
      rxd_oe_n_out <= m0_state != M0_TX;
    end else begin
      txd_out      <= tx_line;
      rxd_out      <= 1'b1;
      rxd_oe_n_out <= 1'b1;
    end
  end

  // read data stands for one cycle only; unmapped reads return zero
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
    end else if (rd_buf) begin
      rdata_out <= rx_buffer;
    end else if (rd_ctrl) begin
      rdata_out <= serial_port_control;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  a_write_starts_tx: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (wr_buf && is_async(mode)) |=> (tx_state == TX_START) ##1 !txd_out)
    else $error("buffer write did not start an async frame");

  a_ti_at_stop: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    $rose(tx_stop) |-> serial_port_control[`TX_DONE_FLAG_POS]
                       ##1 txd_out)
    else $error("tx done flag not set at start of stop bit");

  a_no_rx_disabled: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (rx_state == RX_IDLE && !rx_enable && !wr_ctrl) |=>
      (rx_state == RX_IDLE))
    else $error("reception started while disabled");

  a_mode0_drives_rxd: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (mode == MODE_SHIFT && m0_state == M0_TX && !wr_ctrl) |=>
      (!rxd_oe_n_out && rxd_out == $past(m0_shift[0])))
    else $error("mode 0 transmit does not drive rxd");

  a_mpc_filter: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (rx_finish && has_ninth(mode) && mpe && !rx_ninth_cap &&
     !rx_done && !wr_ctrl) |=> !serial_port_control[`RX_DONE_FLAG_POS])
    else $error("frame with ninth bit 0 set rx done flag");

  a_read_buffer: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    rd_buf |=> (rdata_out == $past(rx_buffer)) ##1
      (rdata_out == 8'h00 || $past(rd_in)))
    else $error("buffer read returned wrong data or held it");

  a_rx_set_wins: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (async_accept || m0_rx_done) |=>
      serial_port_control[`RX_DONE_FLAG_POS])
    else $error("rx done flag lost against a clear");

  a_mode0_rx_start: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (mode == MODE_SHIFT && m0_state == M0_IDLE && rx_enable &&
     !rx_done && !wr_in) ##1 !wr_in |-> (m0_state == M0_RX) [*2])
    else $error("mode 0 reception did not start");

  a_stop_to_rb8: assert property (
    @(posedge clock_in) disable iff (!rstn_in)
    (async_accept && mode == MODE_UART8) |=>
      (serial_port_control[`RX_NINTH_BIT_POS] == $past(rxd_sync)))
    else $error("stop bit not captured in mode 1");

endmodule

//--- test/remote_serial_device.sv
`timescale 1ns/10ps
module remote_serial_device (
  // clock
  input  wire logic clock_in,
  // pins seen from the far side
  input  wire logic txd_in,
  input  wire logic line_in,
  output logic      line_out
);
  // the released line sits at its pull-up level
  initial line_out = 1'b1;

  // frame bits leave lsb first, each held for cpb clocks
  task automatic send_frame(input logic [10:0] bits, input int nbits,
                            input int cpb);
    for (int i = 0; i < nbits; i++) begin
      line_out <= bits[i];
      repeat (cpb) @(posedge clock_in);
    end
    line_out <= 1'b1;
  endtask

  // samples mid-bit, so a few clocks of tick phase do not matter
  task automatic capture_frame(input int ndata, input int cpb,
                               output logic [8:0] data, output logic stop);
    data = 9'h000;
    @(negedge txd_in);
    repeat (cpb / 2) @(posedge clock_in);
    for (int i = 0; i < ndata; i++) begin
      repeat (cpb) @(posedge clock_in);
      data[i] = txd_in;
    end
    repeat (cpb) @(posedge clock_in);
    stop = txd_in;
  endtask

  task automatic capture_shift(output logic [7:0] data);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd_in);
      data[i] = line_in;
    end
  endtask

  // next bit goes out just after the shift clock rises, the edge on
  // which the receiver has already sampled the bit before
  task automatic drive_shift(input logic [7:0] data);
    line_out <= data[0];
    for (int i = 1; i < 9; i++) begin
      @(posedge txd_in);
      @(posedge clock_in);
      line_out <= (i < 8) ? data[i] : 1'b1;
    end
  endtask
endmodule

//--- test/tb_four_mode_serial_port.sv
`timescale 1ns/10ps
`include "serial_port_defines.svh"
module tb_four_mode_serial_port;
  localparam int LIMIT = 30000;

  logic        clock_in           = 1'b0;
  logic        rstn_in            = 1'b0;
  logic  [7:0] addr_in            = 8'h00;
  logic  [7:0] wdata_in           = 8'h00;
  logic        wr_in              = 1'b0;
  logic        rd_in              = 1'b0;
  logic        timer1_ovf_in      = 1'b0;
  logic        timer2_ovf_in      = 1'b0;
  logic        rx_clock_select_in = 1'b0;
  logic        tx_clock_select_in = 1'b0;
  logic        div64_select_in    = 1'b0;
  logic  [7:0] rdata_out;
  logic        rxd_out;
  logic        rxd_oe_n_out;
  logic        txd_out;
  logic        model_line;
  logic        rxd_line;
  logic [31:0] seed               = 32'h0000CB09;
  int          num_errors         = 0;
  int          checks             = 0;
  int          cycles             = 0;

  // the pin carries the device while it drives, else the far side
  assign rxd_line = rxd_oe_n_out ? model_line : rxd_out;

  four_mode_serial_port i_dut (
    .clock_in           (clock_in),
    .rstn_in            (rstn_in),
    .addr_in            (addr_in),
    .wdata_in           (wdata_in),
    .wr_in              (wr_in),
    .rd_in              (rd_in),
    .rdata_out          (rdata_out),
    .timer1_ovf_in      (timer1_ovf_in),
    .timer2_ovf_in      (timer2_ovf_in),
    .rx_clock_select_in (rx_clock_select_in),
    .tx_clock_select_in (tx_clock_select_in),
    .div64_select_in    (div64_select_in),
    .rxd_in             (rxd_line),
    .rxd_out            (rxd_out),
    .rxd_oe_n_out       (rxd_oe_n_out),
    .txd_out            (txd_out)
  );

  remote_serial_device model (
    .clock_in (clock_in),
    .txd_in   (txd_out),
    .line_in  (rxd_line),
    .line_out (model_line)
  );

  always #2.5 clock_in = ~clock_in;

  // timer 1 overflows every 2 clocks, timer 2 every 3: 32 and 48 per bit
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    timer1_ovf_in <= (cycles % 2 == 0);
    timer2_ovf_in <= (cycles % 3 == 0);
    if (cycles == LIMIT) begin
      num_errors++;
      complete_run();
    end
  end

  function automatic logic [7:0] rand_byte();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic complete_run();
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check_val(input logic [8:0] act, input logic [8:0] exp);
    checks++;
    if (act !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  // strobes drop one cycle before the next request may raise them
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
    @(posedge clock_in);
  endtask

  // case fields: 7:6 mode, 5 div64, 4 mp, 3 ninth or stop, 2 rx enable,
  // 1 rewrite control first, 0 rx uses timer 2
  logic [7:0] cases [9] = '{8'h8E, 8'h84, 8'hBE, 8'h96, 8'h8A, 8'h5F,
                            8'h56, 8'h4E, 8'h46};

  initial begin
    logic [7:0]  v;
    logic [7:0]  d;
    logic [7:0]  r;
    logic [7:0]  g8;
    logic [8:0]  g9;
    logic        st;
    logic [7:0]  e;
    logic [7:0]  exp_ctrl;
    logic [7:0]  exp_buf;
    logic [10:0] frame;
    logic        accept;
    int          cpb;
    repeat (12) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    reg_read(`SERIAL_PORT_CONTROL_ADDR, v);
    check_val({1'b0, v}, 9'h000);
    reg_read(`SERIAL_BUFFER_ADDR, v);
    check_val({1'b0, v}, 9'h000);
    reg_write(8'h9A, 8'hFF);
    reg_read(8'h9A, v);
    check_val({1'b0, v}, 9'h000);
    reg_read(`SERIAL_PORT_CONTROL_ADDR, v);
    check_val({1'b0, v}, 9'h000);
    // mode 0 transmit
    d = rand_byte();
    fork
      model.capture_shift(g8);
      reg_write(`SERIAL_BUFFER_ADDR, d);
    join
    repeat (12) @(posedge clock_in);
    check_val({1'b0, g8}, {1'b0, d});
    check_val({8'h00, rxd_oe_n_out}, 9'h001);
    reg_read(`SERIAL_PORT_CONTROL_ADDR, v);
    check_val({1'b0, v}, 9'h002);
    // mode 0 receive starts once enabled with the done flag clear
    d = rand_byte();
    fork
      model.drive_shift(d);
      reg_write(`SERIAL_PORT_CONTROL_ADDR, 8'h10);
    join
    repeat (12) @(posedge clock_in);
    reg_read(`SERIAL_BUFFER_ADDR, v);
    check_val({1'b0, v}, {1'b0, d});
    reg_read(`SERIAL_PORT_CONTROL_ADDR, v);
    check_val({1'b0, v}, 9'h011);
    // mode 1 transmit on timer 1
    reg_write(`SERIAL_PORT_CONTROL_ADDR, 8'h40);
    d = rand_byte();
    fork
      model.capture_frame(8, 32, g9, st);
      reg_write(`SERIAL_BUFFER_ADDR, d);
    join
    check_val(g9, {1'b0, d});
    check_val({8'h00, st}, 9'h001);
    reg_read(`SERIAL_PORT_CONTROL_ADDR, v);
    check_val({1'b0, v}, 9'h042);
    // mode 3 full duplex, transmit on timer 2, receive on timer 1
    tx_clock_select_in <= 1'b1;
    reg_write(`SERIAL_PORT_CONTROL_ADDR, 8'hD8);
    d = rand_byte();
    r = rand_byte();
    fork
      model.capture_frame(9, 48, g9, st);
      model.send_frame({2'b10, r, 1'b0}, 11, 32);
      reg_write(`SERIAL_BUFFER_ADDR, d);
    join
    check_val(g9, {1'b1, d});
    check_val({8'h00, st}, 9'h001);
    reg_read(`SERIAL_BUFFER_ADDR, v);
    check_val({1'b0, v}, {1'b0, r});
    reg_read(`SERIAL_PORT_CONTROL_ADDR, v);
    check_val({1'b0, v}, 9'h0DB);
    // receive table, with a reference of buffer and control
    exp_ctrl = 8'hDB;
    exp_buf  = r;
    for (int k = 0; k < 9; k++) begin
      e = cases[k];
      div64_select_in    <= e[5];
      rx_clock_select_in <= e[0];
      if (e[1]) begin
        exp_ctrl = {e[7:6], e[4], e[2], 4'h0};
        reg_write(`SERIAL_PORT_CONTROL_ADDR, exp_ctrl);
      end
      r = rand_byte();
      cpb = (e[7:6] == 2'h2) ? (e[5] ? 64 : 32) : (e[0] ? 48 : 32);
      frame = {1'b1, e[3], r, 1'b0};
      accept = e[2] && !exp_ctrl[0] && (!e[4] || e[3]);
      model.send_frame(frame, e[7] ? 11 : 10, cpb);
      repeat (8) @(posedge clock_in);
      if (accept) begin
        exp_buf     = r;
        exp_ctrl[0] = 1'b1;
        exp_ctrl[2] = e[3];
      end
      reg_read(`SERIAL_BUFFER_ADDR, v);
      check_val({1'b0, v}, {1'b0, exp_buf});
      reg_read(`SERIAL_PORT_CONTROL_ADDR, v);
      check_val({1'b0, v}, {1'b0, exp_ctrl});
    end
    // mode 2 transmit on the fixed osc/64 rate with ninth bit 0
    div64_select_in <= 1'b1;
    reg_write(`SERIAL_PORT_CONTROL_ADDR, 8'h80);
    d = rand_byte();
    fork
      model.capture_frame(9, 64, g9, st);
      reg_write(`SERIAL_BUFFER_ADDR, d);
    join
    check_val(g9, {1'b0, d});
    check_val({8'h00, st}, 9'h001);
    reg_read(`SERIAL_PORT_CONTROL_ADDR, v);
    check_val({1'b0, v}, 9'h082);
    complete_run();
  end
endmodule
